/* design/ssf_pkg.sv */
// Shared constants, types and word encoding for the status/fault block.
// Assumes a single 10 MHz clock domain and 16-bit network data words.
package ssf_pkg;

  localparam int unsigned CLOCK_HZ    = 10_000_000;
  localparam int unsigned SYNC_STAGES = 2;

  // Network register numbers of the command block.
  localparam logic [15:0] CMD_UPPER_ADDR = 16'h0400;
  localparam logic [15:0] CMD_LOWER_ADDR = 16'h0401;
  localparam logic [15:0] CMD_LAST_ADDR  = 16'h0409;

  // Command word bit positions.
  localparam int unsigned CMD_RESET_ERRORS_BIT = 10;
  localparam int unsigned CMD_CLEAR_FAULT_BIT  = 10;
  localparam int unsigned CMD_ENABLE_BIT       = 15;

  // Second status word bit positions.
  localparam int unsigned STS_ENABLE_BIT = 15;
  localparam int unsigned STS_FAULT_BIT  = 7;
  localparam int unsigned STS_IN3_BIT    = 2;
  localparam int unsigned STS_IN1_BIT    = 0;

  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] CMD_RESET    = 16'h0000;

  // Position limits and the multi-word scale.
  localparam logic signed [31:0] POS_MIN   = -32'sd32768000;
  localparam logic signed [31:0] POS_MAX   = 32'sd32767999;
  localparam logic signed [31:0] POS_SCALE = 32'sd1000;
  localparam logic signed [31:0] POS_ZERO  = 32'sd0;
  localparam logic signed [15:0] WORD_ZERO = 16'sd0;

  typedef enum logic [1:0] {
    IN3_GENERAL      = 2'h0,
    IN3_CAPTURE      = 2'h1,
    IN3_STOP_CAPTURE = 2'h3,
    IN3_OTHER        = 2'h2
  } ssf_in3_func_t;

  // Upper word is the quotient by the scale; truncation toward zero makes it 0 from -999 to 999.
  function automatic logic signed [15:0] word_upper(
    input logic signed [31:0] v
  );
    logic signed [31:0] q;
    q = v / POS_SCALE;
    return q[15:0];
  endfunction

  // Lower word is the signed remainder, never positive for a negative value.
  function automatic logic signed [15:0] word_lower(
    input logic signed [31:0] v
  );
    logic signed [31:0] r;
    r = v % POS_SCALE;
    return r[15:0];
  endfunction

endpackage

/* design/ssf_count_if.sv */
// Carrier between the status block and a position counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ssf_count_if;
  logic               up;
  logic               down;
  logic signed [31:0] count;
  logic signed [15:0] upper;
  logic signed [15:0] lower;

  modport src (output up, down, input count, upper, lower);
  modport cnt (input up, down, output count, upper, lower);
endinterface

/* design/ssf_sync.sv */
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the pins are quasi-static relative to the clock.
`timescale 1ns/1ps
module ssf_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Pins and synchronised levels
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      meta_reg <= '0;
      level    <= '0;
    end
    else
    begin
      meta_reg <= pin;
      level    <= meta_reg;
    end
  end
endmodule

/* design/ssf_pos_counter.sv */
// Saturating signed position counter with multi-word encoded outputs.
// Assumes up and down come from logic on the same clock.
`timescale 1ns/1ps
module ssf_pos_counter #(
  parameter logic signed [31:0] MIN = ssf_pkg::POS_MIN,
  parameter logic signed [31:0] MAX = ssf_pkg::POS_MAX
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Count carrier
  ssf_count_if.cnt cif
);
  logic signed [31:0] count_next;
  wire at_max = (cif.count >= MAX);
  wire at_min = (cif.count <= MIN);
  wire inc    = cif.up && !cif.down && !at_max;
  wire dec    = cif.down && !cif.up && !at_min;

  assign count_next = inc ? cif.count + 32'sd1 :
                      dec ? cif.count - 32'sd1 : cif.count;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      cif.count <= ssf_pkg::POS_ZERO;
      cif.upper <= ssf_pkg::WORD_ZERO;
      cif.lower <= ssf_pkg::WORD_ZERO;
    end
    else
    begin
      cif.count <= count_next;
      cif.upper <= ssf_pkg::word_upper(count_next);
      cif.lower <= ssf_pkg::word_lower(count_next);
    end
  end

  a_count_in_range: assert property
    (@(posedge clock) disable iff (!reset_n)
    (cif.count >= MIN) && (cif.count <= MAX))
    else $error("position count left its range");
  a_count_saturates: assert property
    (@(posedge clock) disable iff (!reset_n)
    (cif.count == MAX) && cif.up && !cif.down |=> cif.count == MAX)
    else $error("position count passed its upper limit");
  a_words_negative: assert property
    (@(posedge clock) disable iff (!reset_n)
    (count_next < 0) && (count_next <= -ssf_pkg::POS_SCALE) |=>
    (cif.upper < 0) && (cif.lower <= 0))
    else $error("negative value sent with a positive word");
  c_count_limit: cover property (@(posedge clock) disable iff (!reset_n)
    cif.count == MAX);
endmodule

/* design/ssf_status_fault.sv */
// Second status word, three position reports and driver-fault clearing.
// Assumes command words arrive as single register writes on the clock,
// and the block is committed by the write to its last register.
`timescale 1ns/1ps
module ssf_status_fault (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Network register writes
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  // Pins
  input  wire logic [2:0]  in_pin,
  input  wire logic        overtemp_pin,
  input  wire logic        short_pin,
  input  wire logic        interlock_missing_pin,
  // Motion logic and configuration
  input  wire logic        step_pulse,
  input  wire logic        step_dir,
  input  wire logic [2:0]  cfg_active_level,
  input  wire logic        cfg_encoder_mode,
  input  wire logic [1:0]  cfg_in3_function,
  input  wire logic        cmd_error_event,
  // Reports
  output logic [15:0]      second_status_word,
  output logic [15:0]      step_pos_upper,
  output logic [15:0]      step_pos_lower,
  output logic [15:0]      enc_pos_upper,
  output logic [15:0]      enc_pos_lower,
  output logic [15:0]      cap_pos_upper,
  output logic [15:0]      cap_pos_lower,
  output logic             command_error,
  output logic             motor_current_on
);
  logic [2:0]  in_level;
  logic [2:0]  fault_level;
  logic [15:0] upper_reg;
  logic [15:0] lower_reg;
  logic        enable_reg;
  logic        fault_reg;
  logic        suppress_reg;
  logic [1:0]  settle_reg;
  logic [1:0]  quad_prev_reg;
  logic        in3_active_reg;
  logic        cmd_err_reg;
  logic [15:0] status_next;

  ssf_count_if step_if ();
  ssf_count_if enc_if ();

  ssf_sync #(.WIDTH(3)) u_in_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .pin     (in_pin),
    .level   (in_level)
  );

  ssf_sync #(.WIDTH(3)) u_fault_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .pin     ({interlock_missing_pin, short_pin, overtemp_pin}),
    .level   (fault_level)
  );

  ssf_pos_counter u_step_cnt (
    .clock   (clock),
    .reset_n (reset_n),
    .cif     (step_if)
  );

  ssf_pos_counter u_enc_cnt (
    .clock   (clock),
    .reset_n (reset_n),
    .cif     (enc_if)
  );

  // Command block decode; words 1026 to 1032 are not stored at all.
  wire wr_upper   = reg_wr && (reg_addr == ssf_pkg::CMD_UPPER_ADDR);
  wire wr_lower   = reg_wr && (reg_addr == ssf_pkg::CMD_LOWER_ADDR);
  wire commit     = reg_wr && (reg_addr == ssf_pkg::CMD_LAST_ADDR);
  wire err_reset  = commit && upper_reg[ssf_pkg::CMD_RESET_ERRORS_BIT];
  wire fault_clr  = err_reset && lower_reg[ssf_pkg::CMD_CLEAR_FAULT_BIT];

  // Input activity and reported flags.
  wire [2:0] in_active = ~(in_level ^ cfg_active_level);
  wire [2:0] in_flags  = {in_active[2], cfg_encoder_mode ?
                          cfg_active_level[1:0] : in_active[1:0]};

  // Quadrature decode on inputs 1 and 2.
  wire [1:0] quad      = in_level[1:0];
  wire       quad_move = (quad[0] ^ quad_prev_reg[0]) ^
                         (quad[1] ^ quad_prev_reg[1]);
  wire       quad_dir  = quad_prev_reg[0] ^ quad[1];
  assign enc_if.up    = cfg_encoder_mode && quad_move && quad_dir;
  assign enc_if.down  = cfg_encoder_mode && quad_move && !quad_dir;

  // Step pulses issued by the motion logic.
  assign step_if.up   = step_pulse && step_dir;
  assign step_if.down = step_pulse && !step_dir;

  // Capture on input 3 activation in a capture function.
  wire in3_func_cap = (cfg_in3_function == ssf_pkg::IN3_CAPTURE) ||
                      (cfg_in3_function == ssf_pkg::IN3_STOP_CAPTURE);
  wire capture      = in3_func_cap && in_active[2] && !in3_active_reg;

  // Power-stage fault detection; a missing jumper at start-up is masked.
  wire settled      = (settle_reg == 2'(ssf_pkg::SYNC_STAGES));
  wire jumper_fault = fault_level[2] && !suppress_reg;
  wire fault_cond   = fault_level[0] || fault_level[1] || jumper_fault;
  wire fault_set    = settled && enable_reg && fault_cond;
  wire fault_shown  = fault_reg && enable_reg;

  always_comb
  begin
    status_next = ssf_pkg::STATUS_RESET;
    status_next[ssf_pkg::STS_ENABLE_BIT] = enable_reg;
    status_next[ssf_pkg::STS_FAULT_BIT]  = fault_shown;
    status_next[ssf_pkg::STS_IN3_BIT:ssf_pkg::STS_IN1_BIT] = in_flags;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      upper_reg <= ssf_pkg::CMD_RESET;
      lower_reg <= ssf_pkg::CMD_RESET;
    end
    else
    begin
      if (wr_upper)
        upper_reg <= reg_wdata;
      if (wr_lower)
        lower_reg <= reg_wdata;
    end
  end

  // Enable follows each committed block; set wins over clear for flags.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      enable_reg  <= 1'b0;
      fault_reg   <= 1'b0;
      cmd_err_reg <= 1'b0;
    end
    else
    begin
      if (commit)
        enable_reg <= lower_reg[ssf_pkg::CMD_ENABLE_BIT];
      fault_reg   <= fault_set || (fault_reg && !fault_clr);
      cmd_err_reg <= cmd_error_event || (cmd_err_reg && !err_reset);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      settle_reg   <= 2'h0;
      suppress_reg <= 1'b1;
    end
    else
    begin
      if (!settled)
        settle_reg <= settle_reg + 2'h1;
      if (settled && !fault_level[2])
        suppress_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      quad_prev_reg  <= 2'h0;
      in3_active_reg <= 1'b0;
      cap_pos_upper  <= 16'h0000;
      cap_pos_lower  <= 16'h0000;
    end
    else
    begin
      quad_prev_reg  <= quad;
      in3_active_reg <= in_active[2];
      if (capture)
      begin
        cap_pos_upper <= ssf_pkg::word_upper(enc_if.count);
        cap_pos_lower <= ssf_pkg::word_lower(enc_if.count);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      second_status_word <= ssf_pkg::STATUS_RESET;
      command_error      <= 1'b0;
      motor_current_on   <= 1'b0;
    end
    else
    begin
      second_status_word <= status_next;
      command_error      <= cmd_err_reg;
      motor_current_on   <= enable_reg && !fault_reg && !fault_set;
    end
  end

  assign step_pos_upper = step_if.upper;
  assign step_pos_lower = step_if.lower;
  assign enc_pos_upper  = enc_if.upper;
  assign enc_pos_lower  = enc_if.lower;

  a_flags_live: assert property
    (@(posedge clock) disable iff (!reset_n)
    !cfg_encoder_mode |=> second_status_word[2:0] == $past(in_active))
    else $error("input flags do not follow input activity");
  a_flags_encoder: assert property
    (@(posedge clock) disable iff (!reset_n)
    cfg_encoder_mode |=>
    second_status_word[1:0] == $past(cfg_active_level[1:0]))
    else $error("encoder mode flags not the active-level settings");
  a_in3_live: assert property
    (@(posedge clock) disable iff (!reset_n)
    cfg_encoder_mode |=> second_status_word[2] == $past(in_active[2]))
    else $error("input 3 flag not live in encoder mode");
  a_capture_value: assert property
    (@(posedge clock) disable iff (!reset_n)
    capture |=> cap_pos_upper == ssf_pkg::word_upper($past(enc_if.count))
            && cap_pos_lower == ssf_pkg::word_lower($past(enc_if.count)))
    else $error("captured words do not match encoder count");
  a_capture_gated: assert property
    (@(posedge clock) disable iff (!reset_n)
    !in3_func_cap |=> $stable(cap_pos_upper) && $stable(cap_pos_lower))
    else $error("capture taken outside a capture function");
  a_enc_idle: assert property
    (@(posedge clock) disable iff (!reset_n)
    !cfg_encoder_mode |=> $stable(enc_if.count))
    else $error("encoder count moved outside encoder mode");
  a_step_track: assert property
    (@(posedge clock) disable iff (!reset_n)
    step_pulse && step_dir && (step_if.count < ssf_pkg::POS_MAX) |=>
    step_if.count == $past(step_if.count) + 32'sd1)
    else $error("issued step not counted");
  a_fault_sets: assert property
    (@(posedge clock) disable iff (!reset_n)
    fault_set |-> ##2
    second_status_word[ssf_pkg::STS_FAULT_BIT] || !enable_reg)
    else $error("fault flag not raised after a fault");
  a_fault_clears: assert property
    (@(posedge clock) disable iff (!reset_n)
    fault_clr && !fault_set |-> ##2
    !second_status_word[ssf_pkg::STS_FAULT_BIT])
    else $error("clear block did not clear the fault flag");
  a_fault_enabled: assert property
    (@(posedge clock) disable iff (!reset_n)
    second_status_word[ssf_pkg::STS_FAULT_BIT] |->
    second_status_word[ssf_pkg::STS_ENABLE_BIT])
    else $error("fault flag shown while stage disabled");
  a_unused_words: assert property
    (@(posedge clock) disable iff (!reset_n)
    reg_wr && (reg_addr > ssf_pkg::CMD_LOWER_ADDR) &&
    (reg_addr < ssf_pkg::CMD_LAST_ADDR) |=>
    $stable(upper_reg) && $stable(lower_reg) && $stable(enable_reg))
    else $error("unused command word changed the block");
  a_enable_follow: assert property
    (@(posedge clock) disable iff (!reset_n)
    commit |=> enable_reg == $past(lower_reg[ssf_pkg::CMD_ENABLE_BIT])
    ##1 !motor_current_on || enable_reg)
    else $error("enable does not follow committed block");
  a_current_off: assert property
    (@(posedge clock) disable iff (!reset_n)
    fault_reg || !enable_reg |=> !motor_current_on)
    else $error("motor current on with a fault or a disabled stage");
  a_boot_mask: assert property
    (@(posedge clock) disable iff (!reset_n)
    suppress_reg && !fault_level[0] && !fault_level[1] |-> !fault_set)
    else $error("missing jumper at start-up raised a fault");
  a_err_reset: assert property
    (@(posedge clock) disable iff (!reset_n)
    err_reset && !cmd_error_event |-> ##2 !command_error)
    else $error("error reset did not clear command error");

  c_fault_cleared: cover property (@(posedge clock) disable iff (!reset_n)
    fault_reg ##1 fault_clr ##1 !fault_reg);
  c_capture: cover property (@(posedge clock) disable iff (!reset_n)
    capture && (enc_if.count < 0));
  c_reenable: cover property (@(posedge clock) disable iff (!reset_n)
    fault_clr ##[1:20] (commit && lower_reg[ssf_pkg::CMD_ENABLE_BIT]));
  c_jumper_fault: cover property (@(posedge clock) disable iff (!reset_n)
    fault_set && fault_level[2] && !fault_level[0] && !fault_level[1]);
endmodule

/* testbench/ssf_host_model.sv */
// Host model that writes command blocks one register per clock.
// Assumes the device clock and a bench that calls write_block.
`timescale 1ns/1ps
module ssf_host_model (
  // Clock
  input  wire logic        clock,
  // Register writes
  output logic             reg_wr,
  output logic      [15:0] reg_addr,
  output logic      [15:0] reg_wdata
);
  initial
  begin
    reg_wr    = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
  end

  // Sends a whole block; the unused words carry all ones.
  task automatic write_block(input logic [15:0] upper,
                             input logic [15:0] lower);
    int i;
    for (i = 0; i < 10; i++)
    begin
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= ssf_pkg::CMD_UPPER_ADDR + 16'(i);
      reg_wdata <= (i == 0) ? upper : (i == 1) ? lower : 16'hffff;
    end
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_addr  <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
  endtask
endmodule

/* testbench/stepper_status_fault_clear_tb_top.sv */
// Self-checking bench for the status and fault-clear block.
// Assumes the host model drives the register writes.
`timescale 1ns/1ps
module stepper_status_fault_clear_tb_top;
  logic        clock, reset_n, overtemp_pin, short_pin, ilk_pin;
  logic        step_pulse, step_dir, cfg_encoder_mode, cmd_error_event;
  logic        reg_wr, cerr, mco;
  logic [15:0] reg_addr, reg_wdata;
  logic [15:0] sts, spu, spl, epu, epl, cap_u, cap_l;
  logic [2:0]  in_pin, cfg_active_level;
  logic [1:0]  cfg_in3_function;
  logic [1:0]  seq [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  int          ph, fails, tests_run;

  ssf_host_model host (
    .clock     (clock),
    .reg_wr    (reg_wr),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata)
  );

  ssf_status_fault dut (
    .clock                 (clock),
    .reset_n               (reset_n),
    .reg_wr                (reg_wr),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .in_pin                (in_pin),
    .overtemp_pin          (overtemp_pin),
    .short_pin             (short_pin),
    .interlock_missing_pin (ilk_pin),
    .step_pulse            (step_pulse),
    .step_dir              (step_dir),
    .cfg_active_level      (cfg_active_level),
    .cfg_encoder_mode      (cfg_encoder_mode),
    .cfg_in3_function      (cfg_in3_function),
    .cmd_error_event       (cmd_error_event),
    .second_status_word    (sts),
    .step_pos_upper        (spu),
    .step_pos_lower        (spl),
    .enc_pos_upper         (epu),
    .enc_pos_lower         (epl),
    .cap_pos_upper         (cap_u),
    .cap_pos_lower         (cap_l),
    .command_error         (cerr),
    .motor_current_on      (mco)
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic print_verdict;
    $display("Checks run %0d, failures %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic t_power_up;
    host.write_block(16'h0000, 16'h8000);
    cyc(4);
    check(sts & 16'h8080, 16'h8000);
    @(posedge clock) ilk_pin <= 1'b0;
    host.write_block(16'h0000, 16'h0000);
    cyc(4);
  endtask

  task automatic t_inputs;
    @(posedge clock) cfg_active_level <= 3'b101;
    in_pin <= 3'b100;
    cyc(4);
    check(sts & 16'h0007, 16'h0006);
    @(posedge clock) in_pin <= 3'b011;
    cyc(4);
    check(sts & 16'h0007, 16'h0001);
    @(posedge clock) in_pin <= 3'b000;
    cyc(4);
    @(posedge clock) cfg_encoder_mode <= 1'b1;
    cfg_active_level <= 3'b110;
    cyc(4);
    check(sts & 16'h0007, 16'h0002);
  endtask

  task automatic quad(input int n, input logic up);
    int i;
    for (i = 0; i < n; i++)
    begin
      ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
      @(posedge clock) in_pin[1:0] <= seq[ph];
      cyc(3);
    end
  endtask

  task automatic t_encoder;
    int f, cnt, cap;
    quad(8, 1'b1);
    check(epl, 16'd8);
    quad(30, 1'b0);
    cnt = -22;
    cap = 0;
    check(epu, 16'h0000);
    check(epl, 16'hffea);
    for (f = 0; f < 4; f++)
    begin
      @(posedge clock) cfg_in3_function <= f[1:0];
      quad(4, 1'b1);
      cnt += 4;
      @(posedge clock) in_pin[2] <= 1'b1;
      cyc(4);
      if (f == 1 || f == 3)
        cap = cnt;
      check(cap_l, 16'(cap));
      check(cap_u, 16'(cap / 1000));
      @(posedge clock) in_pin[2] <= 1'b0;
      cyc(4);
    end
  endtask

  task automatic steps(input int n, input logic dir);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(posedge clock) step_pulse <= 1'b1;
      step_dir <= dir;
      @(posedge clock) step_pulse <= 1'b0;
    end
    cyc(2);
  endtask

  task automatic t_steps;
    steps(1500, 1'b0);
    check(spu, 16'hffff);
    check(spl, 16'hfe0c);
    steps(2501, 1'b1);
    check(spu, 16'h0001);
    check(spl, 16'h0001);
  endtask

  task automatic t_fault;
    int i;
    for (i = 0; i < 3; i++)
    begin
      host.write_block(16'h0000, 16'h8000);
      cyc(4);
      check(sts & 16'h8080, 16'h8000);
      @(posedge clock) {ilk_pin, short_pin, overtemp_pin} <= 3'b001 << i;
      cyc(6);
      check(sts & 16'h8080, 16'h8080);
      check({15'h0, mco}, 16'h0000);
      @(posedge clock) {ilk_pin, short_pin, overtemp_pin} <= 3'b000;
      cyc(4);
      host.write_block(16'h0400, 16'h0400);
      cyc(4);
      check(sts & 16'h8080, 16'h0000);
      check({15'h0, mco}, 16'h0000);
    end
    @(posedge clock) overtemp_pin <= 1'b1;
    cyc(6);
    check(sts & 16'h0080, 16'h0000);
    @(posedge clock) overtemp_pin <= 1'b0;
    cyc(4);
    host.write_block(16'h0000, 16'h8000);
    @(posedge clock) overtemp_pin <= 1'b1;
    cyc(6);
    host.write_block(16'h0000, 16'h0000);
    cyc(4);
    check(sts & 16'h8080, 16'h0000);
    @(posedge clock) overtemp_pin <= 1'b0;
    cyc(4);
    host.write_block(16'h0000, 16'h8000);
    cyc(4);
    check(sts & 16'h8080, 16'h8080);
    check({15'h0, mco}, 16'h0000);
    host.write_block(16'h0400, 16'h0400);
    host.write_block(16'h0000, 16'h8000);
    cyc(4);
    check(sts & 16'h8080, 16'h8000);
    check({15'h0, mco}, 16'h0001);
  endtask

  task automatic t_cmd_error;
    @(posedge clock) cmd_error_event <= 1'b1;
    @(posedge clock) cmd_error_event <= 1'b0;
    cyc(3);
    host.write_block(16'h0000, 16'h0400);
    cyc(4);
    check({15'h0, cerr}, 16'h0001);
    host.write_block(16'h0400, 16'h0000);
    cyc(4);
    check({15'h0, cerr}, 16'h0000);
  endtask

  initial
  begin
    reset_n = 1'b0;
    {overtemp_pin, short_pin, step_pulse, step_dir} = 4'h0;
    {cfg_encoder_mode, cmd_error_event, cfg_in3_function} = 4'h0;
    ilk_pin = 1'b1;
    in_pin = 3'b000;
    cfg_active_level = 3'b111;
    ph = 0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    cyc(1);
    check(sts, 16'h0000);
    t_power_up();
    t_inputs();
    t_encoder();
    t_steps();
    t_fault();
    t_cmd_error();
    print_verdict();
  end

  initial
  begin
    #4_000_000;
    fails++;
    print_verdict();
  end
endmodule
